// File: inc/srfu_defines.svh
// Offsets, field positions, reset values and timing of the shift/rotate/flag unit
`ifndef SRFU_DEFINES_SVH
`define SRFU_DEFINES_SVH

// ****************************************
// Register bus
// ****************************************
`define SRFU_ADDR_W 8
`define SRFU_DATA_W 8
`define SRFU_OFS_OPERAND 8'h00
`define SRFU_OFS_STATUS 8'h04
`define SRFU_OFS_COMMAND 8'h08
`define SRFU_RDATA_IDLE 8'h00

// ****************************************
// Reset values
// ****************************************
`define SRFU_OPERAND_RST 8'h00
`define SRFU_STATUS_RST 8'h00
`define SRFU_COMMAND_RST 7'h00

// ****************************************
// Status register bit positions
// ****************************************
`define SRFU_FLAG_C 0
`define SRFU_FLAG_Z 1
`define SRFU_FLAG_N 2
`define SRFU_FLAG_V 3
`define SRFU_FLAG_S 4
`define SRFU_FLAG_H 5
`define SRFU_FLAG_T 6
`define SRFU_FLAG_I 7

// ****************************************
// Command register fields
// ****************************************
`define SRFU_CMD_OP_MSB 3
`define SRFU_CMD_OP_LSB 0
`define SRFU_CMD_BIT_MSB 6
`define SRFU_CMD_BIT_LSB 4
`define SRFU_CMD_W 7

// ****************************************
// Timing
// ****************************************
`define SRFU_EXEC_CYCLES 1

`endif

// File: inc/srfu_pkg.sv
// Types of the shift/rotate/flag unit
package srfu_pkg;

   // ****************************************
   // Operation codes
   // ****************************************
   typedef enum logic [3:0] {
      NO_OP                   = 4'b0000,
      LOGICAL_SHIFT_RIGHT_OP  = 4'b0001,
      ROTATE_LEFT_CARRY_OP    = 4'b0010,
      ROTATE_RIGHT_CARRY_OP   = 4'b0011,
      ARITH_SHIFT_RIGHT_OP    = 4'b0100,
      BIT_TO_TRANSFER_FLAG_OP = 4'b0101,
      TRANSFER_FLAG_TO_BIT_OP = 4'b0110,
      OVERFLOW_FLAG_SET_OP    = 4'b0111,
      OVERFLOW_FLAG_CLEAR_OP  = 4'b1000,
      SIGN_FLAG_SET_OP        = 4'b1001,
      SIGN_FLAG_CLEAR_OP      = 4'b1010
   } srfu_op_t;

endpackage : srfu_pkg

// File: inc/srfu_calc_if.sv
// Interface between the register block and the operation datapath
`timescale 1ns/1ps
interface srfu_calc_if import srfu_pkg::*;;
   logic [7:0] operand;
   logic [7:0] status;
   srfu_op_t op;
   logic [2:0] bit_sel;
   logic [7:0] result;
   logic [7:0] status_out;

   modport core (
      output operand,
      output status,
      output op,
      output bit_sel,
      input result,
      input status_out
   );

   modport calc (
      input operand,
      input status,
      input op,
      input bit_sel,
      output result,
      output status_out
   );
endinterface : srfu_calc_if

// File: verilog/srfu_calc.sv
// Combinational datapath of the shift/rotate/flag unit
`timescale 1ns/1ps
`include "srfu_defines.svh"
module srfu_calc import srfu_pkg::*; (
   srfu_calc_if.calc bus
);

   logic [7:0] res;
   logic [7:0] st;
   logic new_c;
   logic shift_grp;

   // ****************************************
   // Operation decode
   // ****************************************
   always_comb begin
      res = bus.operand;
      st = bus.status;
      new_c = bus.status[`SRFU_FLAG_C];
      shift_grp = 1'b0;
      case (bus.op)
         LOGICAL_SHIFT_RIGHT_OP: begin
            res = {1'b0, bus.operand[7:1]};
            new_c = bus.operand[0];
            shift_grp = 1'b1;
         end
         ROTATE_LEFT_CARRY_OP: begin
            res = {bus.operand[6:0], bus.status[`SRFU_FLAG_C]};
            new_c = bus.operand[7];
            shift_grp = 1'b1;
         end
         ROTATE_RIGHT_CARRY_OP: begin
            res = {bus.status[`SRFU_FLAG_C], bus.operand[7:1]};
            new_c = bus.operand[0];
            shift_grp = 1'b1;
         end
         ARITH_SHIFT_RIGHT_OP: begin
            res = {bus.operand[7], bus.operand[7:1]};
            new_c = bus.operand[0];
            shift_grp = 1'b1;
         end
         BIT_TO_TRANSFER_FLAG_OP: begin
            st[`SRFU_FLAG_T] = bus.operand[bus.bit_sel];
         end
         TRANSFER_FLAG_TO_BIT_OP: begin
            res[bus.bit_sel] = bus.status[`SRFU_FLAG_T];
         end
         OVERFLOW_FLAG_SET_OP: begin
            st[`SRFU_FLAG_V] = 1'b1;
         end
         OVERFLOW_FLAG_CLEAR_OP: begin
            st[`SRFU_FLAG_V] = 1'b0;
         end
         SIGN_FLAG_SET_OP: begin
            st[`SRFU_FLAG_S] = 1'b1;
         end
         SIGN_FLAG_CLEAR_OP: begin
            st[`SRFU_FLAG_S] = 1'b0;
         end
         default: begin
         end
      endcase
      // Only Z, C, N, V change for shifts; others kept
      if (shift_grp) begin
         st[`SRFU_FLAG_C] = new_c;
         st[`SRFU_FLAG_Z] = (res == 8'h00);
         st[`SRFU_FLAG_N] = res[7];
         st[`SRFU_FLAG_V] = res[7] ^ new_c;
      end
   end

   assign bus.result = res;
   assign bus.status_out = st;

endmodule : srfu_calc

// File: verilog/srfu_top.sv
// Register block of the shift/rotate/flag unit with its checks
`timescale 1ns/1ps
`include "srfu_defines.svh"
module srfu_top import srfu_pkg::*; #(
   parameter int ADDR_W = `SRFU_ADDR_W
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [7:0] RDATA,
   output logic [7:0] RESULT,
   output logic [7:0] STATUS
);

   // ****************************************
   // Reset release
   // ****************************************
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] operand_reg;
   logic [7:0] operand_next;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [`SRFU_CMD_W-1:0] cmd_reg;
   logic [`SRFU_CMD_W-1:0] cmd_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic go;
   srfu_op_t op_w;

   srfu_calc_if calc_bus ();

   srfu_calc u_calc (
      .bus(calc_bus.calc)
   );

   // Command write launches the operation
   assign go = WR_STB && (ADDR == ADDR_W'(`SRFU_OFS_COMMAND));
   assign op_w = go ? srfu_op_t'(WDATA[`SRFU_CMD_OP_MSB:`SRFU_CMD_OP_LSB]) : NO_OP;

   assign calc_bus.operand = operand_reg;
   assign calc_bus.status = status_reg;
   assign calc_bus.op = op_w;
   assign calc_bus.bit_sel = WDATA[`SRFU_CMD_BIT_MSB:`SRFU_CMD_BIT_LSB];

   always_comb begin
      operand_next = operand_reg;
      status_next = status_reg;
      cmd_next = cmd_reg;
      rdata_next = `SRFU_RDATA_IDLE;
      if (WR_STB) begin
         case (ADDR)
            ADDR_W'(`SRFU_OFS_OPERAND): begin
               operand_next = WDATA;
            end
            ADDR_W'(`SRFU_OFS_STATUS): begin
               status_next = WDATA;
            end
            ADDR_W'(`SRFU_OFS_COMMAND): begin
               // Result and flags land on the same edge
               cmd_next = WDATA[`SRFU_CMD_W-1:0];
               operand_next = calc_bus.result;
               status_next = calc_bus.status_out;
            end
            default: begin
            end
         endcase
      end
      if (RD_STB) begin
         case (ADDR)
            ADDR_W'(`SRFU_OFS_OPERAND): begin
               rdata_next = operand_reg;
            end
            ADDR_W'(`SRFU_OFS_STATUS): begin
               rdata_next = status_reg;
            end
            ADDR_W'(`SRFU_OFS_COMMAND): begin
               rdata_next = {1'b0, cmd_reg};
            end
            default: begin
               rdata_next = `SRFU_RDATA_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         operand_reg <= `SRFU_OPERAND_RST;
         status_reg <= `SRFU_STATUS_RST;
         cmd_reg <= `SRFU_COMMAND_RST;
         rdata_reg <= `SRFU_RDATA_IDLE;
      end else begin
         operand_reg <= operand_next;
         status_reg <= status_next;
         cmd_reg <= cmd_next;
         rdata_reg <= rdata_next;
      end
   end

   assign RDATA = rdata_reg;
   assign RESULT = operand_reg;
   assign STATUS = status_reg;

   // ****************************************
   // Checks
   // ****************************************
   logic [7:0] last_op_reg;
   logic [7:0] last_st_reg;
   logic [2:0] last_bit_reg;

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         last_op_reg <= 8'h00;
         last_st_reg <= 8'h00;
         last_bit_reg <= 3'h0;
      end else begin
         last_op_reg <= operand_reg;
         last_st_reg <= status_reg;
         last_bit_reg <= WDATA[`SRFU_CMD_BIT_MSB:`SRFU_CMD_BIT_LSB];
      end
   end

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!rst_n);

   chk_lsr_shift_flags: assert property (
      (op_w == LOGICAL_SHIFT_RIGHT_OP) |=> (operand_reg == {1'b0, last_op_reg[7:1]})
         && (status_reg[`SRFU_FLAG_C] == last_op_reg[0]) && !status_reg[`SRFU_FLAG_N]
         && (status_reg[`SRFU_FLAG_V] == status_reg[`SRFU_FLAG_C])
         && (status_reg[`SRFU_FLAG_Z] == (operand_reg == 8'h00)))
      else $error("logical shift right wrong");

   chk_rol_carry_path: assert property (
      (op_w == ROTATE_LEFT_CARRY_OP) |=> (operand_reg == {last_op_reg[6:0], last_st_reg[`SRFU_FLAG_C]})
         && (status_reg[`SRFU_FLAG_C] == last_op_reg[7])
         && (status_reg[`SRFU_FLAG_N] == operand_reg[7])
         && (status_reg[`SRFU_FLAG_V] == (operand_reg[7] ^ last_op_reg[7])))
      else $error("rotate left wrong");

   chk_ror_carry_path: assert property (
      (op_w == ROTATE_RIGHT_CARRY_OP) |=> (operand_reg == {last_st_reg[`SRFU_FLAG_C], last_op_reg[7:1]})
         && (status_reg[`SRFU_FLAG_C] == last_op_reg[0])
         && (status_reg[`SRFU_FLAG_Z] == (operand_reg == 8'h00)))
      else $error("rotate right wrong");

   chk_asr_sign_keep: assert property (
      (op_w == ARITH_SHIFT_RIGHT_OP) |=> (operand_reg == {last_op_reg[7], last_op_reg[7:1]})
         && (status_reg[`SRFU_FLAG_C] == last_op_reg[0])
         && (status_reg[`SRFU_FLAG_N] == last_op_reg[7]))
      else $error("arithmetic shift right wrong");

   chk_bst_flag_copy: assert property (
      (op_w == BIT_TO_TRANSFER_FLAG_OP) |=> (status_reg[`SRFU_FLAG_T] == last_op_reg[last_bit_reg])
         && (operand_reg == last_op_reg)
         && ((status_reg ^ last_st_reg) & 8'hbf) == 8'h00)
      else $error("bit store wrong");

   chk_bld_bit_copy: assert property (
      (op_w == TRANSFER_FLAG_TO_BIT_OP) |=> (operand_reg[last_bit_reg] == last_st_reg[`SRFU_FLAG_T])
         && (status_reg == last_st_reg))
      else $error("bit load wrong");

   chk_ovf_force: assert property (
      (op_w == OVERFLOW_FLAG_SET_OP || op_w == OVERFLOW_FLAG_CLEAR_OP)
         |=> (status_reg[`SRFU_FLAG_V] == (cmd_reg[`SRFU_CMD_OP_MSB:`SRFU_CMD_OP_LSB] == OVERFLOW_FLAG_SET_OP))
         && ((status_reg ^ last_st_reg) & 8'hf7) == 8'h00 && (operand_reg == last_op_reg))
      else $error("overflow force wrong");

   chk_sign_force: assert property (
      (op_w == SIGN_FLAG_SET_OP || op_w == SIGN_FLAG_CLEAR_OP)
         |=> (status_reg[`SRFU_FLAG_S] == (cmd_reg[`SRFU_CMD_OP_MSB:`SRFU_CMD_OP_LSB] == SIGN_FLAG_SET_OP))
         && ((status_reg ^ last_st_reg) & 8'hef) == 8'h00 && (operand_reg == last_op_reg))
      else $error("sign force wrong");

   chk_other_flags_kept: assert property (
      (op_w inside {LOGICAL_SHIFT_RIGHT_OP, ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP, ARITH_SHIFT_RIGHT_OP})
         |=> ((status_reg ^ last_st_reg) & 8'hf0) == 8'h00)
      else $error("unnamed flag changed");

   chk_read_idle: assert property (
      !$past(RD_STB) |-> (RDATA == 8'h00))
      else $error("read data outside read slot");

   chk_read_slot_data: assert property (
      ($past(RD_STB) && ($past(ADDR) == ADDR_W'(`SRFU_OFS_STATUS))) |-> (RDATA == last_st_reg))
      else $error("status read data wrong");

   chk_asr_flag_set: assert property (
      (op_w == ARITH_SHIFT_RIGHT_OP) |=> (status_reg[`SRFU_FLAG_Z] == (operand_reg == 8'h00))
         && (status_reg[`SRFU_FLAG_V] == (status_reg[`SRFU_FLAG_N] ^ status_reg[`SRFU_FLAG_C])))
      else $error("arithmetic shift flags wrong");

   chk_rol_zero_flag: assert property (
      (op_w == ROTATE_LEFT_CARRY_OP) |=> (status_reg[`SRFU_FLAG_Z] == (operand_reg == 8'h00)))
      else $error("rotate left zero flag wrong");

   chk_bld_rest_kept: assert property (
      (op_w == TRANSFER_FLAG_TO_BIT_OP)
         |=> ((operand_reg ^ last_op_reg) & ~(8'h01 << last_bit_reg)) == 8'h00)
      else $error("bit load touched other bits");

endmodule : srfu_top

// File: verification/srfu_top_bench.sv
// Self-checking bench of the shift/rotate/flag unit
`timescale 1ns/1ps
`include "srfu_defines.svh"
module srfu_top_bench import srfu_pkg::*;;
   // ****************************************
   // Signals and design
   // ****************************************
   logic sys_clk = 1'b0;
   logic rstn;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] rdata;
   logic [7:0] result;
   logic [7:0] status;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [7:0] opnds [6] = '{8'h00, 8'h01, 8'h80, 8'hff, 8'h81, 8'h5a};
   logic [7:0] stss [3] = '{8'h00, 8'hff, 8'ha5};

   always #5 sys_clk = ~sys_clk;

   srfu_top dut_u (
      .SYS_CLK(sys_clk),
      .RSTN(rstn),
      .ADDR(addr),
      .WDATA(wdata),
      .WR_STB(wr_stb),
      .RD_STB(rd_stb),
      .RDATA(rdata),
      .RESULT(result),
      .STATUS(status)
   );

   // ****************************************
   // Reference model of one command
   // ****************************************
   function automatic logic [15:0] model(input logic [3:0] op, input logic [2:0] b,
                                         input logic [7:0] d, input logic [7:0] s);
      logic [7:0] r;
      logic [7:0] f;
      logic sh;
      r = d;
      f = s;
      sh = 1'b0;
      case (op)
         4'h1: begin r = {1'b0, d[7:1]}; f[`SRFU_FLAG_C] = d[0]; sh = 1'b1; end
         4'h2: begin r = {d[6:0], s[`SRFU_FLAG_C]}; f[`SRFU_FLAG_C] = d[7]; sh = 1'b1; end
         4'h3: begin r = {s[`SRFU_FLAG_C], d[7:1]}; f[`SRFU_FLAG_C] = d[0]; sh = 1'b1; end
         4'h4: begin r = {d[7], d[7:1]}; f[`SRFU_FLAG_C] = d[0]; sh = 1'b1; end
         4'h5: f[`SRFU_FLAG_T] = d[b];
         4'h6: r[b] = s[`SRFU_FLAG_T];
         4'h7: f[`SRFU_FLAG_V] = 1'b1;
         4'h8: f[`SRFU_FLAG_V] = 1'b0;
         4'h9: f[`SRFU_FLAG_S] = 1'b1;
         4'ha: f[`SRFU_FLAG_S] = 1'b0;
         default: r = d;
      endcase
      if (sh) begin
         f[`SRFU_FLAG_Z] = (r == 8'h00);
         f[`SRFU_FLAG_N] = r[7];
         f[`SRFU_FLAG_V] = r[7] ^ f[`SRFU_FLAG_C];
      end
      return {r, f};
   endfunction : model

   // ****************************************
   // Bus tasks and checks
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, exp);
      @(posedge sys_clk);
      #1;
      chk(rdata, `SRFU_RDATA_IDLE);
   endtask : rd

   task finish_test;
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [15:0] exp;
      logic [2:0] bsel;
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      repeat (15) @(posedge sys_clk);
      #1;
      chk(result, `SRFU_OPERAND_RST);
      chk(status, `SRFU_STATUS_RST);
      chk(rdata, `SRFU_RDATA_IDLE);
      @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(`SRFU_OFS_COMMAND, {1'b0, `SRFU_COMMAND_RST});
      for (int i = 0; i < 6; i++) begin
         for (int j = 0; j < 3; j++) begin
            for (int k = 0; k < 16; k++) begin
               bsel = 3'(k + i);
               exp = model(4'(k), bsel, opnds[i], stss[j]);
               wr(`SRFU_OFS_OPERAND, opnds[i]);
               wr(`SRFU_OFS_STATUS, stss[j]);
               wr(`SRFU_OFS_COMMAND, {1'b0, bsel, 4'(k)});
               chk(result, exp[15:8]);
               chk(status, exp[7:0]);
               rd(`SRFU_OFS_OPERAND, exp[15:8]);
               rd(`SRFU_OFS_STATUS, exp[7:0]);
               rd(`SRFU_OFS_COMMAND, {1'b0, bsel, 4'(k)});
            end
         end
      end
      wr(8'h0c, 8'h77);
      chk(result, exp[15:8]);
      chk(status, exp[7:0]);
      rd(8'h0c, 8'h00);
      // Reset in mid-run clears the registers
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(result, `SRFU_OPERAND_RST);
      chk(status, `SRFU_STATUS_RST);
      chk(rdata, `SRFU_RDATA_IDLE);
      @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      wr(`SRFU_OFS_COMMAND, 8'h01);
      chk(result, 8'h00);
      chk(status, 8'h02);
      rd(`SRFU_OFS_COMMAND, 8'h01);
      finish_test();
   end
endmodule : srfu_top_bench
